// ===== hdl/tpf_regs.svh
// Purpose: shared constants of the triple port queue flag block
// Assumes: included by bare name, guard against double inclusion
// Notes:   every width, depth, offset and index lives here
`ifndef TPF_REGS_SVH
`define TPF_REGS_SVH

// ----------------------------------------------------------------
// data path widths
// ----------------------------------------------------------------
`define WORD_WIDTH          36
`define HALF_WIDTH          18
`define QUEUE_DEPTH         8
`define COUNT_WIDTH         4

// ----------------------------------------------------------------
// partial flag offsets, in queue words
// ----------------------------------------------------------------
`define ALMOST_EMPTY_OFFSET 4'h2
`define ALMOST_FULL_OFFSET  4'h2
`define DEPTH_COUNT         4'h8

// ----------------------------------------------------------------
// mode pin level and port clock indices
// ----------------------------------------------------------------
`define STANDARD_LEVEL      1'b1
`define PORT_COUNT          3
`define PORT_A_INDEX        0
`define PORT_B_INDEX        1
`define PORT_C_INDEX        2

`endif

// ===== hdl/tpf_pkg.sv
// Purpose: types shared by the triple port queue flag block
// Assumes: tpf_regs.svh supplies the widths
// Notes:   used only as tpf_pkg::name, never imported
`include "tpf_regs.svh"

package tpf_pkg;

	// ----------------------------------------------------------------
	// timing mode
	// ----------------------------------------------------------------
	typedef enum logic {
		MODE_STANDARD,
		MODE_FALL_THROUGH
	} timing_mode_t;

	// ----------------------------------------------------------------
	// port a request as sampled from the pins
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    select_n;
		logic                    enable;
		logic                    write;
		logic [`WORD_WIDTH-1:0]  data;
	} port_a_request_t;

	// ----------------------------------------------------------------
	// registered flag set of one port
	// ----------------------------------------------------------------
	typedef struct packed {
		logic status;
		logic partial_n;
	} port_flags_t;

endpackage : tpf_pkg

// ===== hdl/port_edge.sv
// Purpose: rising edge strobes of the sampled port clocks
// Assumes: port clock levels are synchronous to CLOCK
// Notes:   late strobe follows one cycle after the rise strobe
`timescale 1ns/1ns
`default_nettype none

module port_edge #(
	parameter int N = 3
) (
	// system
	input  wire logic         clock,
	input  wire logic         reset_n,
	// sampled port clock levels
	input  wire logic [N-1:0] level,
	// strobes
	output logic      [N-1:0] rise,
	output logic      [N-1:0] late
);

	logic [N-1:0] level_prev;

	// ----------------------------------------------------------------
	// one detector per port clock
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_edge
			// previous level and delayed strobe
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					// held high so a port clock high at release is no edge
					level_prev[i] <= 1'b1;
					late[i]       <= 1'b0;
				end else begin
					level_prev[i] <= level[i];
					late[i]       <= rise[i];
				end
			end
			assign rise[i] = level[i] & ~level_prev[i];
		end
	endgenerate

endmodule : port_edge

`default_nettype wire

// ===== hdl/queue_buffer.sv
// Purpose: flip-flop queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   count reports words held, full and empty are exact
`timescale 1ns/1ns
`default_nettype none

module queue_buffer #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// system
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	// filling side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// draining side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic      [WIDTH-1:0]         out_data,
	// fill level
	output logic      [$clog2(DEPTH):0]   count
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// status from pointer difference, extra bit tells full from empty
	assign count     = wr_ptr - rd_ptr;
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = store[rd_ptr[AW-1:0]];

	// pointers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// storage, no reset needed since out_valid guards it
	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule : queue_buffer

`default_nettype wire

// ===== hdl/triple_port_fifo_flags.sv
// Purpose: port control and status flags of a three port queue pair
// Assumes: every pin is synchronous to CLOCK, port clocks sampled
// Notes:   port clocks become strobes, one clock domain throughout
// Notes on behaviour
// - port b transfers timed by port b clock
// - port b flags change on port b rises
// - port c transfers timed by port c clock
// - port c flags change on port c rises
// - port a access needs select low
// - port a outputs float when deselected
// - port b read needs select low
// - port b outputs float when deselected
// - port a access needs enable high
// - standard mode: port a empty flag
// - fall through: port a output ready
// - port a empty flag on port a rises
// - standard mode: port b empty flag
// - fall through: port b output ready
// - standard mode: port a full flag
// - fall through: port a input ready
// - port a full flag on port a rises
// - standard mode: port c full flag
// - fall through: port c input ready
// - mode pin latched after reset release
// - almost empty low at offset or below
// - almost full low at offset or below
`timescale 1ns/1ns
`default_nettype none
`include "tpf_regs.svh"

module triple_port_fifo_flags (
	// system
	input  wire logic                    CLOCK,
	input  wire logic                    RESETN,
	// timing mode pin
	input  wire logic                    FALL_THROUGH_MODE_SELECT,
	// port a control
	input  wire logic                    PORT_A_CLOCK,
	input  wire logic                    PORT_A_SELECT_N,
	input  wire logic                    PORT_A_ENABLE,
	input  wire logic                    PORT_A_WRITE,
	// port a data pin as three signals
	input  wire logic [`WORD_WIDTH-1:0]  PORT_A_DATA_IN,
	output logic      [`WORD_WIDTH-1:0]  PORT_A_DATA_OUT,
	output logic                         PORT_A_DATA_OE,
	// port a flags
	output logic                         PORT_A_EMPTY_N_OR_READY,
	output logic                         PORT_A_FULL_N_OR_READY,
	// port b control
	input  wire logic                    PORT_B_CLOCK,
	input  wire logic                    PORT_B_SELECT_N,
	input  wire logic                    PORT_B_READ_ENABLE,
	// port b data
	output logic      [`HALF_WIDTH-1:0]  PORT_B_DATA_OUT,
	output logic                         PORT_B_DATA_OE,
	// port b flags
	output logic                         PORT_B_EMPTY_N_OR_READY,
	output logic                         PORT_B_ALMOST_EMPTY_N,
	// port c control and data
	input  wire logic                    PORT_C_CLOCK,
	input  wire logic                    PORT_C_WRITE_ENABLE,
	input  wire logic [`HALF_WIDTH-1:0]  PORT_C_DATA,
	// port c flags
	output logic                         PORT_C_FULL_N_OR_READY,
	output logic                         PORT_C_ALMOST_FULL_N
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------

	logic reset_meta;
	logic reset_n;

	// two stage release, assertion stays asynchronous
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			reset_meta <= 1'b0;
			reset_n    <= 1'b0;
		end else begin
			reset_meta <= 1'b1;
			reset_n    <= reset_meta;
		end
	end

	// ----------------------------------------------------------------
	// timing mode
	// ----------------------------------------------------------------

	tpf_pkg::timing_mode_t mode;
	logic                  mode_taken;
	logic                  fall_through;

	// mode pin capture
	// caught once after release; later changes of the pin are ignored
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			mode       <= tpf_pkg::MODE_STANDARD;
			mode_taken <= 1'b0;
		end else if (!mode_taken) begin
			mode_taken <= 1'b1;
			if (FALL_THROUGH_MODE_SELECT == `STANDARD_LEVEL) begin
				mode <= tpf_pkg::MODE_STANDARD;
			end else begin
				mode <= tpf_pkg::MODE_FALL_THROUGH;
			end
		end
	end

	assign fall_through = (mode == tpf_pkg::MODE_FALL_THROUGH);

	// ----------------------------------------------------------------
	// port clock strobes
	// ----------------------------------------------------------------

	logic [`PORT_COUNT-1:0] port_level;
	logic [`PORT_COUNT-1:0] port_rise;
	logic [`PORT_COUNT-1:0] port_late;
	logic                   a_rise;
	logic                   b_rise;
	logic                   c_rise;
	logic                   a_late;
	logic                   b_late;
	logic                   c_late;

	assign port_level[`PORT_A_INDEX] = PORT_A_CLOCK;
	assign port_level[`PORT_B_INDEX] = PORT_B_CLOCK;
	assign port_level[`PORT_C_INDEX] = PORT_C_CLOCK;

	port_edge #(
		.N       (`PORT_COUNT)
	) u_edge (
		.clock   (CLOCK),
		.reset_n (reset_n),
		.level   (port_level),
		.rise    (port_rise),
		.late    (port_late)
	);

	assign a_rise = port_rise[`PORT_A_INDEX];
	assign b_rise = port_rise[`PORT_B_INDEX];
	assign c_rise = port_rise[`PORT_C_INDEX];
	assign a_late = port_late[`PORT_A_INDEX];
	assign b_late = port_late[`PORT_B_INDEX];
	assign c_late = port_late[`PORT_C_INDEX];

	// ----------------------------------------------------------------
	// queues
	// ----------------------------------------------------------------

	logic                    ab_in_valid;
	logic                    ab_in_ready;
	logic                    ab_out_valid;
	logic                    ab_out_ready;
	logic [`WORD_WIDTH-1:0]  ab_out_data;
	logic [`COUNT_WIDTH-1:0] ab_count;
	logic                    ca_in_valid;
	logic                    ca_in_ready;
	logic [`WORD_WIDTH-1:0]  ca_in_data;
	logic                    ca_out_valid;
	logic                    ca_out_ready;
	logic [`WORD_WIDTH-1:0]  ca_out_data;
	logic [`COUNT_WIDTH-1:0] ca_count;

	// a_to_b_queue: port a writes, port b reads
	queue_buffer #(
		.WIDTH     (`WORD_WIDTH),
		.DEPTH     (`QUEUE_DEPTH)
	) u_a_to_b_queue (
		.clock     (CLOCK),
		.reset_n   (reset_n),
		.in_valid  (ab_in_valid),
		.in_ready  (ab_in_ready),
		.in_data   (PORT_A_DATA_IN),
		.out_valid (ab_out_valid),
		.out_ready (ab_out_ready),
		.out_data  (ab_out_data),
		.count     (ab_count)
	);

	// c_to_a_queue: port c writes, port a reads
	queue_buffer #(
		.WIDTH     (`WORD_WIDTH),
		.DEPTH     (`QUEUE_DEPTH)
	) u_c_to_a_queue (
		.clock     (CLOCK),
		.reset_n   (reset_n),
		.in_valid  (ca_in_valid),
		.in_ready  (ca_in_ready),
		.in_data   (ca_in_data),
		.out_valid (ca_out_valid),
		.out_ready (ca_out_ready),
		.out_data  (ca_out_data),
		.count     (ca_count)
	);

	// ----------------------------------------------------------------
	// port a
	// ----------------------------------------------------------------

	tpf_pkg::port_a_request_t a_req;
	tpf_pkg::port_flags_t     a_flags;
	logic                     a_access;
	logic                     a_read;
	logic [`WORD_WIDTH-1:0]   a_word;
	logic                     a_word_valid;
	logic                     a_fetch;

	assign a_req = '{select_n: PORT_A_SELECT_N, enable: PORT_A_ENABLE,
		write: PORT_A_WRITE, data: PORT_A_DATA_IN};

	assign a_access = a_rise & ~a_req.select_n & a_req.enable;

	// write into a_to_b_queue; a full queue refuses it silently
	assign ab_in_valid = a_access & a_req.write;

	// standard reads need a word queued, fall through needs one shown
	assign a_read = a_access & ~a_req.write &
		(fall_through ? a_word_valid : ca_out_valid);

	// prefetch only on port a rises
	assign a_fetch = fall_through ?
		(a_rise & (~a_word_valid | a_read) & ca_out_valid) : a_read;
	assign ca_out_ready = a_fetch;

	// output word register
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			a_word       <= '0;
			a_word_valid <= 1'b0;
		end else if (a_fetch) begin
			a_word       <= ca_out_data;
			a_word_valid <= 1'b1;
		end else if (a_read) begin
			a_word_valid <= 1'b0;
		end
	end

	// flags follow the port a rise
	// sampled a cycle late so the access of that rise is counted
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			a_flags <= '0;
		end else if (a_late) begin
			a_flags.status    <= fall_through ? a_word_valid : ca_out_valid;
			a_flags.partial_n <= ab_in_ready;
		end
	end

	assign PORT_A_DATA_OUT         = a_word;
	assign PORT_A_EMPTY_N_OR_READY = a_flags.status;
	assign PORT_A_FULL_N_OR_READY  = a_flags.partial_n;
	assign PORT_A_DATA_OE          = ~a_req.select_n & ~a_req.write;

	// ----------------------------------------------------------------
	// port b, two half words per queue word, low half first
	// ----------------------------------------------------------------

	tpf_pkg::port_flags_t   b_flags;
	logic                   b_access;
	logic [`WORD_WIDTH-1:0] b_word;
	logic                   b_valid;
	logic                   b_half;
	logic [`HALF_WIDTH-1:0] b_data;
	logic                   b_fetch;
	logic                   b_advance;

	// read gate on port b rise
	assign b_access = b_rise & ~PORT_B_SELECT_N & PORT_B_READ_ENABLE;

	// a read on the high half, or an empty stage, needs a new word
	assign b_advance = fall_through ?
		(b_rise & (~b_valid | (b_access & b_half))) :
		(b_access & ~b_half);
	assign b_fetch      = b_advance & ab_out_valid;
	assign ab_out_ready = b_fetch;

	// half word stage
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			b_word  <= '0;
			b_valid <= 1'b0;
			b_half  <= 1'b0;
			b_data  <= '0;
		end else if (b_fetch) begin
			b_word  <= ab_out_data;
			b_valid <= 1'b1;
			b_half  <= ~fall_through;
			b_data  <= ab_out_data[`HALF_WIDTH-1:0];
		end else if (b_advance) begin
			b_valid <= 1'b0;
			b_half  <= 1'b0;
		end else if (b_access & (b_valid | b_half)) begin
			b_half  <= ~b_half;
			// the low half went out on fetch, so this read shows the upper one
			b_data  <= b_word[`WORD_WIDTH-1:`HALF_WIDTH];
			b_valid <= fall_through ? 1'b1 : 1'b0;
		end
	end

	// flags follow the port b rise
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			b_flags <= '0;
		end else if (b_late) begin
			b_flags.status    <= fall_through ? b_valid :
				(b_half | ab_out_valid);
			b_flags.partial_n <= (ab_count > `ALMOST_EMPTY_OFFSET);
		end
	end

	assign PORT_B_DATA_OUT         = b_data;
	assign PORT_B_EMPTY_N_OR_READY = b_flags.status;
	assign PORT_B_ALMOST_EMPTY_N   = b_flags.partial_n;
	assign PORT_B_DATA_OE          = ~PORT_B_SELECT_N;

	// ----------------------------------------------------------------
	// port c, two half words build one queue word, low half first
	// ----------------------------------------------------------------

	tpf_pkg::port_flags_t    c_flags;
	logic                    c_access;
	logic                    c_half;
	logic [`HALF_WIDTH-1:0]  c_low;
	logic [`COUNT_WIDTH-1:0] ca_free;

	// write gate on port c rise, refused while full
	assign c_access    = c_rise & PORT_C_WRITE_ENABLE & ca_in_ready;
	assign ca_in_valid = c_access & c_half;
	assign ca_in_data  = {PORT_C_DATA, c_low};
	assign ca_free     = `DEPTH_COUNT - ca_count;

	// low half holding register
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			c_half <= 1'b0;
			c_low  <= '0;
		end else if (c_access) begin
			c_half <= ~c_half;
			if (!c_half) begin
				c_low <= PORT_C_DATA;
			end
		end
	end

	// flags follow the port c rise
	always_ff @(posedge CLOCK or negedge reset_n) begin
		if (!reset_n) begin
			c_flags <= '0;
		end else if (c_late) begin
			c_flags.status    <= ca_in_ready;
			c_flags.partial_n <= (ca_free > `ALMOST_FULL_OFFSET);
		end
	end

	assign PORT_C_FULL_N_OR_READY = c_flags.status;
	assign PORT_C_ALMOST_FULL_N   = c_flags.partial_n;

endmodule : triple_port_fifo_flags

`default_nettype wire

// ===== verification/tpf_flags_asserts.sv
// Purpose: port level checks of the queue flag block
// Assumes: port clocks are sampled levels, one CLOCK domain
// Notes:   refresh windows follow the port strobe pipeline
`timescale 1ns/1ns
`default_nettype none
`include "tpf_regs.svh"

module tpf_flags_asserts (
	// system
	input wire logic                   CLOCK,
	input wire logic                   RESETN,
	// port clocks
	input wire logic                   PORT_A_CLOCK,
	input wire logic                   PORT_B_CLOCK,
	input wire logic                   PORT_C_CLOCK,
	// port a
	input wire logic                   PORT_A_SELECT_N,
	input wire logic                   PORT_A_WRITE,
	input wire logic [`WORD_WIDTH-1:0] PORT_A_DATA_OUT,
	input wire logic                   PORT_A_DATA_OE,
	input wire logic                   PORT_A_EMPTY_N_OR_READY,
	input wire logic                   PORT_A_FULL_N_OR_READY,
	// port b
	input wire logic                   PORT_B_SELECT_N,
	input wire logic [`HALF_WIDTH-1:0] PORT_B_DATA_OUT,
	input wire logic                   PORT_B_DATA_OE,
	input wire logic                   PORT_B_EMPTY_N_OR_READY,
	input wire logic                   PORT_B_ALMOST_EMPTY_N,
	// port c
	input wire logic                   PORT_C_FULL_N_OR_READY,
	input wire logic                   PORT_C_ALMOST_FULL_N
);
	// ----------------------------------------------------------
	// port clock rises as CLOCK sees them
	// ----------------------------------------------------------
	logic [2:0] clk_q;
	logic [2:0] rise;

	// previous sample of each port clock
	always_ff @(posedge CLOCK) begin
		clk_q <= {PORT_C_CLOCK, PORT_B_CLOCK, PORT_A_CLOCK};
	end
	assign rise = {PORT_C_CLOCK, PORT_B_CLOCK, PORT_A_CLOCK} & ~clk_q;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	// flags refresh one to three edges after their own rise
	sequence late_rise(r);
		$past(r, 1) || $past(r, 2) || $past(r, 3);
	endsequence
	// data may move from the rise up to three edges later
	sequence near_rise(r);
		r || $past(r, 1) || $past(r, 2) || $past(r, 3);
	endsequence

	chk_a_bus_drive: assert property (
		PORT_A_DATA_OE == (!PORT_A_SELECT_N && !PORT_A_WRITE))
		else $error("port a drive enable wrong");
	chk_b_bus_drive: assert property (
		PORT_B_DATA_OE == !PORT_B_SELECT_N)
		else $error("port b drive enable wrong");
	chk_a_empty_rise: assert property (
		$changed(PORT_A_EMPTY_N_OR_READY) |-> late_rise(rise[0]))
		else $error("port a empty flag off its clock");
	chk_a_full_rise: assert property (
		$changed(PORT_A_FULL_N_OR_READY) |-> late_rise(rise[0]))
		else $error("port a full flag off its clock");
	chk_b_flags_rise: assert property (
		$changed({PORT_B_EMPTY_N_OR_READY, PORT_B_ALMOST_EMPTY_N})
		|-> late_rise(rise[1])) else $error("port b flags off clock");
	chk_c_flags_rise: assert property (
		$changed({PORT_C_FULL_N_OR_READY, PORT_C_ALMOST_FULL_N})
		|-> late_rise(rise[2])) else $error("port c flags off clock");
	chk_a_data_rise: assert property (
		$changed(PORT_A_DATA_OUT) |-> near_rise(rise[0]))
		else $error("port a data moved without a rise");
	chk_b_data_rise: assert property (
		$changed(PORT_B_DATA_OUT) |-> near_rise(rise[1]))
		else $error("port b data moved without a rise");
	chk_c_full_almost: assert property (
		!PORT_C_FULL_N_OR_READY |-> !PORT_C_ALMOST_FULL_N)
		else $error("port c full without almost full");
	chk_b_empty_almost: assert property (
		!PORT_B_EMPTY_N_OR_READY |-> !PORT_B_ALMOST_EMPTY_N)
		else $error("port b empty without almost empty");
endmodule : tpf_flags_asserts

bind triple_port_fifo_flags tpf_flags_asserts u_chk (
	.CLOCK, .RESETN, .PORT_A_CLOCK, .PORT_B_CLOCK, .PORT_C_CLOCK,
	.PORT_A_SELECT_N, .PORT_A_WRITE, .PORT_A_DATA_OUT, .PORT_A_DATA_OE,
	.PORT_A_EMPTY_N_OR_READY, .PORT_A_FULL_N_OR_READY,
	.PORT_B_SELECT_N, .PORT_B_DATA_OUT, .PORT_B_DATA_OE,
	.PORT_B_EMPTY_N_OR_READY, .PORT_B_ALMOST_EMPTY_N,
	.PORT_C_FULL_N_OR_READY, .PORT_C_ALMOST_FULL_N
);
`default_nettype wire

// ===== verification/port_clock_model.sv
// Purpose: free running clocks of the three port masters
// Assumes: stepped on the falling edge of the system clock
// Notes:   period of eight system cycles, phases staggered
`timescale 1ns/1ns
`default_nettype none

module port_clock_model (
	// system
	input  wire logic clock,
	// port clocks
	output logic      a_clk,
	output logic      b_clk,
	output logic      c_clk
);
	logic [2:0] phase = 3'h0;

	always_ff @(negedge clock) begin
		phase <= phase + 3'h1;
	end

	// staggered so a flag tied to the wrong port shows up
	assign a_clk = phase[2];
	assign b_clk = phase[2] ^ phase[1];
	assign c_clk = ~phase[2];
endmodule : port_clock_model
`default_nettype wire

// ===== verification/triple_port_fifo_port_control_flags_tb.sv
// Purpose: self-checking bench of the queue flag block
// Assumes: port clocks come from port_clock_model
// Notes:   controls change only while their port clock is low, bar the t_a_drain and t_b_drain drive probes
`timescale 1ns/1ns
`default_nettype none
`include "tpf_regs.svh"

module triple_port_fifo_port_control_flags_tb;
	logic                   clock, resetn, mode;
	logic                   a_sel_n, a_en, a_wr, b_sel_n, b_ren, c_wen;
	logic [`WORD_WIDTH-1:0] a_din, a_dout;
	logic [`HALF_WIDTH-1:0] c_din, b_dout;
	logic                   a_oe, a_ef, a_ff, b_oe, b_ef, b_ae, c_ff, c_af;
	logic [2:0]             pclk;
	int                     bad_count, checks;

	// 250 MHz system clock
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	port_clock_model pcm (.clock(clock), .a_clk(pclk[0]),
		.b_clk(pclk[1]), .c_clk(pclk[2]));

	triple_port_fifo_flags dut (
		.CLOCK(clock), .RESETN(resetn), .FALL_THROUGH_MODE_SELECT(mode),
		.PORT_A_CLOCK(pclk[0]), .PORT_A_SELECT_N(a_sel_n),
		.PORT_A_ENABLE(a_en), .PORT_A_WRITE(a_wr),
		.PORT_A_DATA_IN(a_din), .PORT_A_DATA_OUT(a_dout),
		.PORT_A_DATA_OE(a_oe), .PORT_A_EMPTY_N_OR_READY(a_ef),
		.PORT_A_FULL_N_OR_READY(a_ff), .PORT_B_CLOCK(pclk[1]),
		.PORT_B_SELECT_N(b_sel_n), .PORT_B_READ_ENABLE(b_ren),
		.PORT_B_DATA_OUT(b_dout), .PORT_B_DATA_OE(b_oe),
		.PORT_B_EMPTY_N_OR_READY(b_ef), .PORT_B_ALMOST_EMPTY_N(b_ae),
		.PORT_C_CLOCK(pclk[2]), .PORT_C_WRITE_ENABLE(c_wen),
		.PORT_C_DATA(c_din), .PORT_C_FULL_N_OR_READY(c_ff),
		.PORT_C_ALMOST_FULL_N(c_af)
	);

	// ----------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [35:0] word(input int i);
		return {14'h1555, 4'(i), 14'h2AAA, 4'(i)};
	endfunction : word

	// looked at 1 ns after the edge so the model has updated
	task automatic wait_lvl(input int p, input logic v);
		do begin
			@(negedge clock);
			#1;
		end while (pclk[p] !== v);
	endtask : wait_lvl

	// long enough for every port to rise and refresh its flags
	task automatic settle;
		repeat (16) @(negedge clock);
	endtask : settle

	task automatic a_op(input logic s, e, w, input logic [35:0] d);
		wait_lvl(0, 1'h0);
		{a_sel_n, a_en, a_wr, a_din} = {s, e, w, d};
		wait_lvl(0, 1'h1);
		wait_lvl(0, 1'h0);
		{a_sel_n, a_en} = 2'h2;
	endtask : a_op

	task automatic b_op(input logic s, r);
		wait_lvl(1, 1'h0);
		{b_sel_n, b_ren} = {s, r};
		wait_lvl(1, 1'h1);
		wait_lvl(1, 1'h0);
		{b_sel_n, b_ren} = 2'h2;
	endtask : b_op

	task automatic c_op(input logic w, input logic [17:0] d);
		wait_lvl(2, 1'h0);
		{c_wen, c_din} = {w, d};
		wait_lvl(2, 1'h1);
		wait_lvl(2, 1'h0);
		c_wen = 1'h0;
	endtask : c_op

	task automatic do_reset(input logic m);
		resetn = 1'h0;
		mode = m;
		repeat (8) @(negedge clock);
		resetn = 1'h1;
		settle;
	endtask : do_reset

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_idle;
		chk(36'(a_ef), 36'h0);
		chk(36'(a_ff), 36'h1);
		chk(36'(b_ef), 36'h0);
		chk(36'(b_ae), 36'h0);
		chk(36'(c_ff), 36'h1);
		chk(36'(c_af), 36'h1);
		a_op(1'h1, 1'h1, 1'h1, word(9));
		a_op(1'h0, 1'h0, 1'h1, word(9));
		settle;
		chk(36'(b_ef), 36'h0);
	endtask : t_idle

	task automatic t_a_fill;
		for (int i = 0; i < 9; i++) begin
			a_op(1'h0, 1'h1, 1'h1, word(i));
			settle;
			if (i == 1) chk(36'(b_ae), 36'h0);
			if (i == 2) chk(36'(b_ae), 36'h1);
			if (i == 6) chk(36'(a_ff), 36'h1);
		end
		chk(36'(a_ff), 36'h0);
		chk(36'(b_ef), 36'h1);
	endtask : t_a_fill

	task automatic t_b_drain;
		logic [35:0] w;
		b_op(1'h1, 1'h1);
		settle;
		chk(36'(b_dout), 36'h0);
		chk(36'(b_oe), 36'h0);
		b_sel_n = 1'h0;
		#1;
		chk(36'(b_oe), 36'h1);
		b_sel_n = 1'h1;
		for (int i = 0; i < 8; i++) begin
			w = word(i);
			b_op(1'h0, 1'h1);
			chk(36'(b_dout), 36'(w[17:0]));
			b_op(1'h0, 1'h1);
			chk(36'(b_dout), 36'(w[35:18]));
		end
		b_op(1'h0, 1'h1);
		settle;
		chk(36'(b_dout), 36'(w[35:18]));
		chk(36'(b_ef), 36'h0);
		chk(36'(a_ff), 36'h1);
	endtask : t_b_drain

	task automatic t_c_fill;
		logic [35:0] w;
		for (int i = 0; i < 9; i++) begin
			w = word(i + 4);
			c_op(1'h1, w[17:0]);
			c_op(1'h1, w[35:18]);
			settle;
			if (i == 4) chk(36'(c_af), 36'h1);
			if (i == 5) chk(36'(c_af), 36'h0);
			if (i == 6) chk(36'(c_ff), 36'h1);
		end
		chk(36'(c_ff), 36'h0);
		chk(36'(a_ef), 36'h1);
	endtask : t_c_fill

	task automatic t_a_drain;
		a_sel_n = 1'h0;
		a_wr = 1'h0;
		#1;
		chk(36'(a_oe), 36'h1);
		a_wr = 1'h1;
		#1;
		chk(36'(a_oe), 36'h0);
		@(negedge clock);
		a_sel_n = 1'h1;
		for (int i = 0; i < 8; i++) begin
			a_op(1'h0, 1'h1, 1'h0, 36'h0);
			chk(a_dout, word(i + 4));
		end
		settle;
		chk(36'(a_ef), 36'h0);
		chk(36'(c_ff), 36'h1);
	endtask : t_a_drain

	task automatic t_fall_through_mode_select;
		logic [35:0] w;
		w = word(5);
		chk(36'(a_ff), 36'h1);
		chk(36'(c_ff), 36'h1);
		chk(36'(a_ef), 36'h0);
		chk(36'(b_ef), 36'h0);
		a_op(1'h0, 1'h1, 1'h1, w);
		settle;
		chk(36'(b_ef), 36'h1);
		chk(36'(b_dout), 36'(w[17:0]));
		b_op(1'h0, 1'h1);
		chk(36'(b_dout), 36'(w[35:18]));
		b_op(1'h0, 1'h1);
		settle;
		chk(36'(b_ef), 36'h0);
		c_op(1'h1, w[17:0]);
		c_op(1'h1, w[35:18]);
		settle;
		chk(36'(a_ef), 36'h1);
		chk(a_dout, w);
		a_op(1'h0, 1'h1, 1'h0, 36'h0);
		settle;
		chk(36'(a_ef), 36'h0);
	endtask : t_fall_through_mode_select

	task automatic results;
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// main sequence: standard mode first, then fall through
	initial begin
		{resetn, mode, a_sel_n, b_sel_n} = 4'h7;
		{a_en, a_wr, b_ren, c_wen} = 4'h0;
		a_din = 36'h0;
		c_din = 18'h0;
		bad_count = 0;
		checks = 0;
		do_reset(1'h1);
		t_idle;
		t_a_fill;
		t_b_drain;
		t_c_fill;
		t_a_drain;
		do_reset(1'h0);
		t_fall_through_mode_select;
		results;
	end

	// watchdog, far beyond the thousand or so cycles the run needs
	initial begin
		repeat (30000) @(posedge clock);
		bad_count++;
		results;
	end
endmodule : triple_port_fifo_port_control_flags_tb
`default_nettype wire
